// File: core/pms_top.sv
// Notes on behaviour
// - Each of four temperature warnings raises an event on both crossing directions.
// - Overtemperature shuts down only after persisting through 8.0 ms.
// - While thermally protected, turn-on is ignored until temperature falls below release.
// - Power-up allowed only after input supply crossed the rising undervoltage threshold.
// - Register access is refused in coin cell state.
// - Interrupt output may be active only in sleep, standby and on.
// - Enter on with supply good and button asserted; release host reset there.
// - From on, supply falling below threshold moves to coin cell.
// - Off drives host reset low; only core and backup supplies stay up.
// - Config 0 with sleep disabled: power off as soon as button is low.
// - Config 1, sleep off, reset enabled: power off after button low 4.0 s.
// - Auto-restart bit makes the device restart after a button power-off from on or standby.
// - Standby request is pin XOR invert bit 6 of power control.
// - Standby pin is ignored outside the on and standby states.
// - Leave standby back to on once standby request deasserts.
// - At first power-up standby regulator settings copy the on settings.
// - Standby delay field bits 5:4 holds off response 0 to 3 slow periods.
// - Standby input is synchronised over three extra slow clock cycles.
// - Button-off with sleep enabled enters sleep; button asserted leaves it.
// - In sleep, bucks with sleep bit 0 turn off, others run PFM at off set point.
// - Retention option keeps first and third linear regulators in low power in sleep.
// - Coin cell rejects turn-on, holds reset low, goes off when supply returns.
// - From standby or on, thermal shutdown or button-off with sleep disabled goes off.
module pms_top
	import pms_pkg::*;
#(
	parameter int unsigned THERM_DEB = THERM_DEB_CYC,
	parameter int unsigned BTN_LONG = BTN_LONG_CYC
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic power_button_in_i,
	input wire logic standby_pin_i,
	input wire logic vin_above_uv_i,
	input wire logic temp_over_i,
	input wire logic [NUM_WARN-1:0] temp_warn_sense_bits_i,
	input wire logic irq_pending_i,
	input pms_cfg_t cfg_i,
	input pms_reg_req_t reg_req_i,
	input wire logic [7:0] on_setting_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_ack_o,
	output logic reg_refused_o,
	output logic [NUM_WARN-1:0] temp_warn_event_o,
	output logic interrupt_out_n_o,
	output logic host_reset_out_n_o,
	output pms_state_t state_o,
	output logic [NUM_BUCK-1:0] buck_en_o,
	output logic [NUM_BUCK-1:0] buck_pfm_o,
	output logic buck_use_off_setpoint_o,
	output logic linear_reg_first_lp_o,
	output logic linear_reg_third_lp_o,
	output logic regs_enable_o,
	output logic standby_active_o,
	output logic [7:0] stby_setting_o
);
	pms_state_t state_ff, nxt_state;
	logic [7:0] pwr_ctrl_ff;
	logic [NUM_WARN-1:0] warn_prev_ff;
	logic [31:0] deb_cnt_ff;
	logic therm_prot_ff;
	logic [31:0] btn_cnt_ff;
	logic btn_long_ff;
	logic uv_armed_ff;
	logic restart_ff;
	logic first_up_ff;
	logic [15:0] div_ff;
	logic tick;
	logic stby_raw;
	logic stby_req;
	logic btn_off;
	logic all_sleep_off;
	logic retain_lp;

	function automatic logic in_active(input pms_state_t s);
		in_active = (s == ST_ON) || (s == ST_STBY) || (s == ST_SLEEP);
	endfunction

	function automatic logic in_run(input pms_state_t s);
		in_run = (s == ST_ON) || (s == ST_STBY);
	endfunction

	// Slow tick emulates the 32 kHz period from the system clock
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_ff <= 16'h0;
		end else if (div_ff == 16'(SLOW_DIV - 1)) begin
			div_ff <= 16'h0;
		end else begin
			div_ff <= div_ff + 16'h1;
		end
	end
	assign tick = (div_ff == 16'(SLOW_DIV - 1));

	// Pin matters in on and standby; in standby it keeps its level so exit can be seen
	assign stby_raw = in_run(state_ff) ?
		(standby_pin_i ^ pwr_ctrl_ff[STBY_INV_BIT]) : 1'b0;

	pms_stby_sync u_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.tick_i(tick),
		.req_i(stby_raw),
		.dly_i(pwr_ctrl_ff[STBY_DLY_HI:STBY_DLY_LO]),
		.req_o(stby_req)
	);

	// Register port; refused in coin cell
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pwr_ctrl_ff <= PWR_CTRL_RST;
			reg_rdata_o <= 8'h0;
			reg_ack_o <= 1'b0;
			reg_refused_o <= 1'b0;
		end else begin
			reg_ack_o <= 1'b0;
			reg_refused_o <= 1'b0;
			reg_rdata_o <= 8'h0;
			if (reg_req_i.wr || reg_req_i.rd) begin
				if (state_ff == ST_COIN) begin
					reg_refused_o <= 1'b1;
				end else begin
					reg_ack_o <= 1'b1;
					if (reg_req_i.addr == PWR_CTRL_ADDR) begin
						if (reg_req_i.wr) begin
							pwr_ctrl_ff <= reg_req_i.wdata;
						end
						reg_rdata_o <= pwr_ctrl_ff;
					end
				end
			end
		end
	end

	// Warning edges in both directions
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			warn_prev_ff <= '0;
			temp_warn_event_o <= '0;
		end else begin
			warn_prev_ff <= temp_warn_sense_bits_i;
			temp_warn_event_o <= warn_prev_ff ^ temp_warn_sense_bits_i;
		end
	end

	// Overtemperature debounce; protection drops only when comparator releases
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			deb_cnt_ff <= 32'h0;
			therm_prot_ff <= 1'b0;
		end else if (!temp_over_i) begin
			deb_cnt_ff <= 32'h0;
			therm_prot_ff <= 1'b0;
		end else if (deb_cnt_ff >= 32'(THERM_DEB - 1)) begin
			therm_prot_ff <= 1'b1;
		end else begin
			deb_cnt_ff <= deb_cnt_ff + 32'h1;
		end
	end

	// Long-press timer; strictly longer than the limit
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			btn_cnt_ff <= 32'h0;
			btn_long_ff <= 1'b0;
		end else if (power_button_in_i) begin
			btn_cnt_ff <= 32'h0;
			btn_long_ff <= 1'b0;
		end else if (btn_cnt_ff >= 32'(BTN_LONG)) begin
			btn_long_ff <= 1'b1;
		end else begin
			btn_cnt_ff <= btn_cnt_ff + 32'h1;
		end
	end

	// Undervoltage arm: registered copy of the supply-good input, one cycle behind it; a fall disarms
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			uv_armed_ff <= 1'b0;
		end else begin
			uv_armed_ff <= vin_above_uv_i;
		end
	end

	assign all_sleep_off = (cfg_i.sleep_mode_enable_bit == '0);
	assign retain_lp = (nxt_state == ST_SLEEP) && cfg_i.low_power_state_retention;
	assign btn_off = cfg_i.button_config_bit ?
		(btn_long_ff && cfg_i.button_reset_enable_bit) :
		!power_button_in_i;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_OFF: begin
				if (!vin_above_uv_i) begin
					nxt_state = ST_COIN;
				end else if (uv_armed_ff && !therm_prot_ff &&
					(power_button_in_i || restart_ff)) begin
					nxt_state = ST_ON;
				end
			end
			ST_COIN: begin
				if (vin_above_uv_i) begin
					nxt_state = ST_OFF;
				end
			end
			ST_SLEEP: begin
				if (!vin_above_uv_i) begin
					nxt_state = ST_COIN;
				end else if (therm_prot_ff) begin
					nxt_state = ST_OFF;
				end else if (cfg_i.button_config_bit && btn_long_ff &&
					cfg_i.button_reset_enable_bit) begin
					nxt_state = ST_OFF;
				end else if (power_button_in_i) begin
					nxt_state = ST_ON;
				end
			end
			ST_STBY: begin
				if (!vin_above_uv_i) begin
					nxt_state = ST_COIN;
				end else if (therm_prot_ff || (btn_off && all_sleep_off)) begin
					nxt_state = ST_OFF;
				end else if (btn_off) begin
					nxt_state = ST_SLEEP;
				end else if (!stby_req) begin
					nxt_state = ST_ON;
				end
			end
			ST_ON: begin
				if (!vin_above_uv_i) begin
					nxt_state = ST_COIN;
				end else if (therm_prot_ff || (btn_off && all_sleep_off)) begin
					nxt_state = ST_OFF;
				end else if (btn_off) begin
					nxt_state = ST_SLEEP;
				end else if (stby_req) begin
					nxt_state = ST_STBY;
				end
			end
			default: nxt_state = ST_OFF;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff <= ST_OFF;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Restart request survives only until the next turn-on
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			restart_ff <= 1'b0;
		end else if (nxt_state == ST_ON) begin
			restart_ff <= 1'b0;
		end else if (in_run(state_ff) && nxt_state == ST_OFF &&
			!therm_prot_ff && cfg_i.auto_restart_bit) begin
			restart_ff <= 1'b1;
		end
	end

	// Standby settings mirror on settings until the first power-up completes
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			first_up_ff <= 1'b1;
			stby_setting_o <= 8'h0;
		end else if (first_up_ff) begin
			stby_setting_o <= on_setting_i;
			if (state_ff == ST_ON) begin
				first_up_ff <= 1'b0;
			end
		end
	end

	// Outputs are registered from the next state so they line up with the state register
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_o <= ST_OFF;
		end else begin
			state_o <= nxt_state;
		end
	end

	// Masking happens upstream; this stage only gates the pin by state
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			interrupt_out_n_o <= 1'b1;
		end else begin
			interrupt_out_n_o <= !(in_active(nxt_state) && irq_pending_i);
		end
	end

	// Host stays in reset whenever its supplies may be down
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			host_reset_out_n_o <= 1'b0;
		end else begin
			host_reset_out_n_o <= in_active(nxt_state);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			regs_enable_o <= 1'b0;
			standby_active_o <= 1'b0;
		end else begin
			regs_enable_o <= in_run(nxt_state);
			standby_active_o <= (nxt_state == ST_STBY);
		end
	end

	// Bucks without their sleep bit drop out; the rest run PFM on the off set point
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			buck_en_o <= '0;
			buck_pfm_o <= '0;
			buck_use_off_setpoint_o <= 1'b0;
		end else if (nxt_state == ST_SLEEP) begin
			buck_en_o <= cfg_i.sleep_mode_enable_bit;
			buck_pfm_o <= cfg_i.sleep_mode_enable_bit;
			buck_use_off_setpoint_o <= 1'b1;
		end else begin
			buck_en_o <= {NUM_BUCK{in_run(nxt_state)}};
			buck_pfm_o <= '0;
			buck_use_off_setpoint_o <= 1'b0;
		end
	end

	// Retention keeps only the first and third linear regulators, in low power
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			linear_reg_first_lp_o <= 1'b0;
			linear_reg_third_lp_o <= 1'b0;
		end else begin
			linear_reg_first_lp_o <= retain_lp;
			linear_reg_third_lp_o <= retain_lp;
		end
	end
endmodule

// File: core/pms_pkg.sv
package pms_pkg;
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned SLOW_HZ = 32768;
	localparam int unsigned SLOW_DIV = CLK_HZ / SLOW_HZ;
	localparam int unsigned THERM_DEB_US = 8000;
	localparam int unsigned THERM_DEB_CYC = (THERM_DEB_US * (CLK_HZ / 1000000));
	localparam int unsigned BTN_LONG_MS = 4000;
	localparam int unsigned BTN_LONG_CYC = BTN_LONG_MS * (CLK_HZ / 1000);
	localparam int unsigned STBY_SYNC_TICKS = 3;
	localparam logic [7:0] PWR_CTRL_ADDR = 8'h1b;
	localparam logic [7:0] PWR_CTRL_RST = 8'h10;
	localparam int unsigned STBY_INV_BIT = 6;
	localparam int unsigned STBY_DLY_LO = 4;
	localparam int unsigned STBY_DLY_HI = 5;
	localparam int unsigned NUM_BUCK = 4;
	localparam int unsigned NUM_WARN = 4;

	typedef enum logic [4:0] {
		ST_OFF = 5'h01,
		ST_COIN = 5'h02,
		ST_SLEEP = 5'h04,
		ST_STBY = 5'h08,
		ST_ON = 5'h10
	} pms_state_t;

	typedef struct packed {
		logic button_config_bit;
		logic button_reset_enable_bit;
		logic auto_restart_bit;
		logic low_power_state_retention;
		logic [NUM_BUCK-1:0] sleep_mode_enable_bit;
	} pms_cfg_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pms_reg_req_t;
endpackage

// File: core/pms_stby_sync.sv
module pms_stby_sync
	import pms_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic tick_i,
	input wire logic req_i,
	input wire logic [1:0] dly_i,
	output logic req_o
);
	logic [STBY_SYNC_TICKS-1:0] sync_ff;
	logic [1:0] cnt_ff;
	logic held_ff;

	// Three slow ticks qualify the asynchronous pin
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync_ff <= '0;
		end else if (tick_i) begin
			sync_ff <= {sync_ff[STBY_SYNC_TICKS-2:0], req_i};
		end
	end

	// Assertion is held off by the programmed count; deassertion is immediate
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_ff <= 2'h0;
			held_ff <= 1'b0;
		end else if (!sync_ff[STBY_SYNC_TICKS-1]) begin
			cnt_ff <= 2'h0;
			held_ff <= 1'b0;
		end else if (!held_ff) begin
			if (cnt_ff >= dly_i) begin
				held_ff <= 1'b1;
			end else if (tick_i) begin
				cnt_ff <= cnt_ff + 2'h1;
			end
		end
	end

	assign req_o = held_ff;
endmodule

// File: verification/pms_host.sv
module pms_host
	import pms_pkg::*;
(
	input wire logic want_i,
	input wire logic inv_i,
	output logic pin_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pin follows the polarity the host programmed; held past sync plus delay
	assign pin_o = want_i ^ inv_i;
endmodule

// File: verification/pms_top_sva.sv
module pms_top_sva
	import pms_pkg::*;
#(
	parameter int unsigned THERM_DEB = 20,
	parameter int unsigned BTN_LONG = 30
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic vin_above_uv_i,
	input wire logic temp_over_i,
	input wire logic [NUM_WARN-1:0] temp_warn_sense_bits_i,
	input pms_reg_req_t reg_req_i,
	input wire logic reg_ack_o,
	input wire logic reg_refused_o,
	input wire logic [NUM_WARN-1:0] temp_warn_event_o,
	input wire logic interrupt_out_n_o,
	input wire logic host_reset_out_n_o,
	input pms_state_t state_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int unsigned tcnt_ff;
	logic req;
	logic act;
	assign req = reg_req_i.wr || reg_req_i.rd;
	assign act = state_o inside {ST_SLEEP, ST_STBY, ST_ON};
	// Margin of two cycles so the debounce edge itself is not judged
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tcnt_ff <= 0;
		end else begin
			tcnt_ff <= temp_over_i ? tcnt_ff + 1 : 0;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_int_gated: assert property (!interrupt_out_n_o |-> act || $past(act))
		else $error("int active in idle state");
	a_off_reset: assert property (state_o == ST_OFF [*2] |-> !host_reset_out_n_o)
		else $error("reset released in off");
	a_coin_reset: assert property (state_o == ST_COIN [*2] |-> !host_reset_out_n_o)
		else $error("reset released in coin");
	a_coin_refuse: assert property (req && state_o == ST_COIN |=>
		reg_refused_o && !reg_ack_o) else $error("access not refused");
	a_reg_ack: assert property (req && state_o != ST_COIN |=>
		reg_ack_o && !reg_refused_o) else $error("access not acked");
	a_uv_coin: assert property (state_o == ST_ON && !vin_above_uv_i |=>
		state_o == ST_COIN) else $error("no coin entry");
	a_therm_hold: assert property (state_o == ST_OFF && temp_over_i &&
		tcnt_ff > THERM_DEB + 2 |=> state_o == ST_OFF) else $error("left off while hot");
	a_warn_event: assert property ($changed(temp_warn_sense_bits_i) |->
		##[1:2] temp_warn_event_o != '0) else $error("no warn event");
endmodule
bind pms_top pms_top_sva #(.THERM_DEB(THERM_DEB), .BTN_LONG(BTN_LONG)) pms_top_sva_inst (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .vin_above_uv_i(vin_above_uv_i),
	.temp_over_i(temp_over_i), .temp_warn_sense_bits_i(temp_warn_sense_bits_i),
	.reg_req_i(reg_req_i), .reg_ack_o(reg_ack_o), .reg_refused_o(reg_refused_o),
	.temp_warn_event_o(temp_warn_event_o), .interrupt_out_n_o(interrupt_out_n_o),
	.host_reset_out_n_o(host_reset_out_n_o), .state_o(state_o));

// File: verification/power_mode_state_machine_bench.sv
module power_mode_state_machine_bench
	import pms_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0, rst_n_i = 1'b0, btn = 1'b0, want = 1'b0, inv = 1'b0, vin = 1'b1;
	logic tov = 1'b0, irq = 1'b0, pin, ack, refd, hrn, inn, lp1, lp3, uoff, ren, sta;
	logic [7:0] onset = 8'h5a;
	logic [3:0] sns = 4'h0;
	logic [3:0] wev, ben, bpf;
	logic [7:0] rd, ss, q;
	pms_cfg_t cfg = '0;
	pms_reg_req_t req = '0;
	pms_state_t st;
	int n_fail = 0, compares = 0, cyc, d;
	pms_host pms_host_inst (.want_i(want), .inv_i(inv), .pin_o(pin));
	pms_top #(.THERM_DEB(20), .BTN_LONG(30)) pms_top_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .power_button_in_i(btn), .standby_pin_i(pin),
		.vin_above_uv_i(vin), .temp_over_i(tov), .temp_warn_sense_bits_i(sns),
		.irq_pending_i(irq), .cfg_i(cfg), .reg_req_i(req), .on_setting_i(onset),
		.reg_rdata_o(rd), .reg_ack_o(ack), .reg_refused_o(refd), .temp_warn_event_o(wev),
		.interrupt_out_n_o(inn), .host_reset_out_n_o(hrn), .state_o(st), .buck_en_o(ben),
		.buck_pfm_o(bpf), .buck_use_off_setpoint_o(uoff), .linear_reg_first_lp_o(lp1),
		.linear_reg_third_lp_o(lp3), .regs_enable_o(ren), .standby_active_o(sta),
		.stby_setting_o(ss));
	initial begin
		forever #25 clk_i = ~clk_i;
	end
	task results();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	// Polls at falling edges so a one-cycle state is still caught
	task wst(input pms_state_t s, input int n);
		for (cyc = 0; cyc < n && st !== s; cyc++) @(negedge clk_i);
		chk("state", st, s);
		if (st !== s) results();
	endtask
	task stay(input pms_state_t s, input int n);
		repeat (n) @(negedge clk_i);
		chk("state", st, s);
	endtask
	task acc(input logic w, input logic [7:0] a, input logic [7:0] dt);
		@(negedge clk_i);
		req = '{w, !w, a, dt};
		@(negedge clk_i);
		req = '0;
		q = rd;
	endtask
	task ev(input logic [3:0] v);
		logic [3:0] e;
		@(negedge clk_i);
		e = v ^ sns;
		sns = v;
		for (cyc = 0; cyc < 3 && wev === 4'h0; cyc++) @(negedge clk_i);
		chk("event", wev, e);
		if (wev !== e) results();
	endtask
	initial begin
		repeat (3) @(negedge clk_i);
		rst_n_i = 1'b1;
		acc(1'b0, 8'h1b, 8'h00);
		chk("reset value", q, 8'h10);
		chk("host reset", hrn, 1'b0);
		acc(1'b0, 8'h20, 8'h00);
		chk("unmapped", q, 8'h00);
		btn = 1'b1;
		wst(ST_ON, 10);
		repeat (2) @(negedge clk_i);
		chk("host reset", hrn, 1'b1);
		chk("mirror", ss, 8'h5a);
		onset = 8'ha5;
		$display("test power on done");
		for (d = 0; d < 4; d++) begin
			acc(1'b1, 8'h1b, 8'(d << 4));
			want = 1'b1;
			wst(ST_STBY, (5 + d) * SLOW_DIV);
			chk("delay", cyc >= (2 + d) * SLOW_DIV && cyc <= (4 + d) * SLOW_DIV + 20, 1'b1);
			chk("stby flags", {ren, sta}, 8'h03);
			want = 1'b0;
			wst(ST_ON, 5 * SLOW_DIV);
		end
		chk("mirror held", ss, 8'h5a);
		$display("test standby done");
		irq = 1'b1;
		cfg = pms_cfg_t'(8'h13);
		btn = 1'b0;
		wst(ST_SLEEP, 10);
		repeat (2) @(negedge clk_i);
		chk("sleep bucks", {ben, bpf}, 8'h33);
		chk("sleep lp", {uoff, lp1, lp3}, 8'h07);
		chk("int", inn, 1'b0);
		want = 1'b1;
		stay(ST_SLEEP, 4 * SLOW_DIV);
		btn = 1'b1;
		wst(ST_ON, 10);
		stay(ST_ON, SLOW_DIV);
		want = 1'b0;
		stay(ST_ON, 4 * SLOW_DIV);
		cfg = '0;
		btn = 1'b0;
		wst(ST_OFF, 10);
		repeat (2) @(negedge clk_i);
		chk("int", inn, 1'b1);
		chk("off supplies", {ren, sta, ben}, 8'h00);
		acc(1'b1, 8'h1b, 8'h50);
		inv = 1'b1;
		$display("test sleep and off done");
		for (d = 0; d < 2; d++) begin
			btn = 1'b1;
			cfg = '0;
			wst(ST_ON, 10);
			cfg = pms_cfg_t'(d ? 8'he0 : 8'hc0);
			btn = 1'b0;
			stay(ST_ON, 30);
			wst(ST_OFF, 10);
		end
		wst(ST_ON, 20);
		btn = 1'b1;
		cfg = '0;
		$display("test button done");
		tov = 1'b1;
		repeat (10) @(negedge clk_i);
		tov = 1'b0;
		stay(ST_ON, 10);
		tov = 1'b1;
		wst(ST_OFF, 40);
		stay(ST_OFF, 20);
		tov = 1'b0;
		wst(ST_ON, 20);
		vin = 1'b0;
		wst(ST_COIN, 10);
		acc(1'b1, 8'h1b, 8'h00);
		chk("refused", {refd, ack}, 8'h02);
		chk("coin reset", hrn, 1'b0);
		stay(ST_COIN, 10);
		vin = 1'b1;
		wst(ST_OFF, 10);
		wst(ST_ON, 20);
		acc(1'b0, 8'h1b, 8'h00);
		chk("no coin write", q, 8'h50);
		$display("test thermal and coin done");
		ev(4'h5);
		ev(4'h0);
		want = 1'b1;
		wst(ST_STBY, 6 * SLOW_DIV);
		want = 1'b0;
		wst(ST_ON, 5 * SLOW_DIV);
		$display("test polarity done");
		results();
	end
endmodule
